// [core/spsa_device.sv]
// device end: serial slave with status, control and id registers
// assumes link pins are asynchronous and user inputs are on core_clk_in
//
// The strobed register port is this design's own decision.
`include "spsa_regs.svh"
`default_nettype none

// Functional notes
// - sample input on rise, shift output on fall
// - idle select: ignore clock, output released
// - only 16-pulse frames acted on, else error
// - bad command or address flags error
// - select fall: enable output, load response
// - select rise: release output, act on word
// - host moves select only with clock low
// - both words shifted msb first together
// - response comes from last error-free frame's command or bad-address status write
// - check command echoes low 12, top 0111
// - self-test clear: host status writes only clear
// - self-test set freezes fault updates
// - device updates non-fault bits itself while self-test clear
// - non-existent bits read zero, ignore writes
// - sensor reg bit0 sticky overheat, bit3 absent
// - id register read-only: model and revision
// - faulted indication reads one, normal zero
// - each device has its own select line
// - sensor reg bits 7-4 peak magnitude
// - bits 2 and 1 follow clamp activity
// - frame error flag is bit 3 reg 13
module spsa_device
#(
    parameter logic [2:0] MODEL_ID = 3'h5, // arbitrary value
    parameter logic [4:0] REV_ID   = 5'h03 // arbitrary value
)
(
    input  wire logic    core_clk_in,
    input  wire logic    rstn_in,
    spsa_link_if.device  link,
    input  wire logic [3:0] peak_code_in,
    input  wire logic    pos_clamp_in,
    input  wire logic    neg_clamp_in,
    input  wire logic    overheat_in,
    output logic         self_test_enable_out,
    output logic         spi_error_out,
    output logic         kline_overheat_flag_out,
    output logic         frame_ok_out
);

    spsa_pkg::spsa_dev_t s_ff;
    spsa_pkg::spsa_dev_t nxt_s;

    logic             sel_fall;
    logic             sel_rise;
    logic             sclk_rise;
    logic             sclk_fall;
    logic             err_evt;
    logic             self_test;
    logic [3:0]       addr;
    logic [7:0]       wdata;
    spsa_pkg::spsa_cmd_t cmd;

    // host write to a status register honouring self-test mode
    function automatic logic [7:0] stat_write
    (
        input logic [7:0] cur,
        input logic [7:0] data,
        input logic [7:0] mask,
        input logic       st
    );
        stat_write = (st ? data : (cur & data)) & mask;
    endfunction : stat_write

    // read value of a status register, zero when unmapped
    function automatic logic [7:0] stat_read
    (
        input spsa_pkg::spsa_dev_t s,
        input logic [3:0]          a
    );
        case (a)
            `SPSA_REG_SENSOR: stat_read = s.sensor & `SPSA_SENSOR_MASK;
            `SPSA_REG_SYSFLT: stat_read = s.sysflt & `SPSA_SYSFLT_MASK;
            `SPSA_REG_ID:     stat_read = {MODEL_ID, REV_ID};
            default:          stat_read = 8'h00;
        endcase
    endfunction : stat_read

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.sclk_sync = {s_ff.sclk_sync[1:0], link.sclk};
        nxt_s.sel_sync  = {s_ff.sel_sync[1:0], link.select_n};
        nxt_s.mosi_sync = {s_ff.mosi_sync[0], link.mosi};
        nxt_s.frame_ok  = 1'b0;
        self_test = s_ff.ctrl[`SPSA_SELFTEST_BIT];
        cmd   = spsa_pkg::spsa_cmd_t'(s_ff.in_sh[15:12]);
        addr  = s_ff.in_sh[11:8];
        wdata = s_ff.in_sh[7:0];
        err_evt = 1'b0;

        sel_fall  = s_ff.sel_sync[2] & ~s_ff.sel_sync[1];
        sel_rise  = ~s_ff.sel_sync[2] & s_ff.sel_sync[1];
        // clock edges only count while selected
        sclk_rise = ~s_ff.sel_sync[1] & ~s_ff.sclk_sync[2]
                    & s_ff.sclk_sync[1];
        sclk_fall = ~s_ff.sel_sync[1] & s_ff.sclk_sync[2]
                    & ~s_ff.sclk_sync[1];

        if (sel_fall)
        begin
            nxt_s.out_sh    = s_ff.resp;
            nxt_s.miso      = s_ff.resp[15];
            nxt_s.miso_oe_n = 1'b0;
            nxt_s.pulses    = 5'h00;
        end
        else if (sclk_rise)
        begin
            nxt_s.in_sh = {s_ff.in_sh[14:0], s_ff.mosi_sync[1]};
            if (s_ff.pulses != `SPSA_PULSE_MAX)
            begin
                nxt_s.pulses = s_ff.pulses + 5'h01;
            end
        end
        else if (sclk_fall)
        begin
            nxt_s.out_sh = {s_ff.out_sh[14:0], 1'b0};
            nxt_s.miso   = s_ff.out_sh[14];
        end

        if (sel_rise)
        begin
            nxt_s.miso_oe_n = 1'b1;
            nxt_s.miso      = 1'b0;
            if (s_ff.pulses != `SPSA_FRAME_BITS)
            begin
                err_evt = 1'b1;
            end
            else
            begin
                case (cmd)
                    spsa_pkg::CMD_CHECK:
                    begin
                        nxt_s.resp = {`SPSA_CHECK_ECHO,
                                      s_ff.in_sh[11:0]};
                    end
                    spsa_pkg::CMD_RD_STAT:
                    begin
                        if (addr == `SPSA_REG_SENSOR
                            || addr == `SPSA_REG_SYSFLT
                            || addr == `SPSA_REG_ID)
                        begin
                            nxt_s.resp = {s_ff.in_sh[15:8],
                                          stat_read(s_ff, addr)};
                        end
                        else
                        begin
                            err_evt = 1'b1;
                        end
                    end
                    spsa_pkg::CMD_WR_STAT:
                    begin
                        nxt_s.resp = s_ff.in_sh;
                        case (addr)
                            `SPSA_REG_SENSOR:
                            begin
                                nxt_s.sensor = stat_write(s_ff.sensor,
                                    wdata, `SPSA_SENSOR_MASK, self_test);
                            end
                            `SPSA_REG_SYSFLT:
                            begin
                                nxt_s.sysflt = stat_write(s_ff.sysflt,
                                    wdata, `SPSA_SYSFLT_MASK, self_test);
                            end
                            `SPSA_REG_ID:
                            begin
                                nxt_s.resp = s_ff.in_sh;
                            end
                            default:
                            begin
                                err_evt = 1'b1;
                            end
                        endcase
                    end
                    spsa_pkg::CMD_RD_CTRL:
                    begin
                        if (addr == `SPSA_REG_CTRL)
                        begin
                            nxt_s.resp = {s_ff.in_sh[15:8],
                                          s_ff.ctrl & `SPSA_CTRL_MASK};
                        end
                        else
                        begin
                            err_evt = 1'b1;
                        end
                    end
                    spsa_pkg::CMD_WR_CTRL:
                    begin
                        if (addr == `SPSA_REG_CTRL)
                        begin
                            nxt_s.resp = s_ff.in_sh;
                            nxt_s.ctrl = wdata & `SPSA_CTRL_MASK;
                        end
                        else
                        begin
                            err_evt = 1'b1;
                        end
                    end
                    default:
                    begin
                        err_evt = 1'b1;
                    end
                endcase
                nxt_s.frame_ok = ~err_evt;
            end
        end

        // hardware updates after host writes so a set wins
        if (!self_test)
        begin
            nxt_s.sensor[`SPSA_PEAK_MSB:`SPSA_PEAK_LSB] = peak_code_in;
            nxt_s.sensor[`SPSA_POS_CLAMP_BIT] = pos_clamp_in;
            nxt_s.sensor[`SPSA_NEG_CLAMP_BIT] = neg_clamp_in;
            if (overheat_in)
            begin
                nxt_s.sensor[`SPSA_OVERHEAT_BIT] = 1'b1;
            end
            if (err_evt)
            begin
                nxt_s.sysflt[`SPSA_SPI_ERR_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            s_ff           <= '0;
            s_ff.sclk_sync <= 3'h0;
            s_ff.sel_sync  <= 3'h7;
            s_ff.resp      <= `SPSA_RESP_RST;
            s_ff.sensor    <= `SPSA_SENSOR_RST;
            s_ff.sysflt    <= `SPSA_SYSFLT_RST;
            s_ff.ctrl      <= `SPSA_CTRL_RST;
            s_ff.miso_oe_n <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign link.miso               = s_ff.miso;
    assign link.miso_oe_n          = s_ff.miso_oe_n;
    assign self_test_enable_out    = s_ff.ctrl[`SPSA_SELFTEST_BIT];
    assign spi_error_out           = s_ff.sysflt[`SPSA_SPI_ERR_BIT];
    assign kline_overheat_flag_out = s_ff.sensor[`SPSA_OVERHEAT_BIT];
    assign frame_ok_out            = s_ff.frame_ok;

endmodule : spsa_device

`default_nettype wire

// [core/spsa_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the design files
`ifndef SPSA_REGS_SVH
`define SPSA_REGS_SVH

`define SPSA_FRAME_BITS    5'd16
`define SPSA_PULSE_MAX     5'd31
`define SPSA_REG_SENSOR    4'hb
`define SPSA_REG_SYSFLT    4'hd
`define SPSA_REG_CTRL      4'he
`define SPSA_REG_ID        4'hf
`define SPSA_OVERHEAT_BIT  0
`define SPSA_NEG_CLAMP_BIT 1
`define SPSA_POS_CLAMP_BIT 2
`define SPSA_PEAK_LSB      4
`define SPSA_PEAK_MSB      7
`define SPSA_SPI_ERR_BIT   3
`define SPSA_SELFTEST_BIT  0
`define SPSA_SENSOR_MASK   8'hf7
`define SPSA_SYSFLT_MASK   8'h08
`define SPSA_CTRL_MASK     8'h01
`define SPSA_SENSOR_RST    8'h00
`define SPSA_SYSFLT_RST    8'h00
`define SPSA_CTRL_RST      8'h00
`define SPSA_RESP_RST      16'h0000
`define SPSA_CHECK_ECHO    4'h7
`define SPSA_HALF_CYCLES   4'h8
`define SPSA_HOST_TX_ADDR  4'h0
`define SPSA_HOST_RX_ADDR  4'h4
`define SPSA_HOST_ST_ADDR  4'h8

`endif

// [core/spsa_pkg.sv]
// types shared by both ends of the serial status link
// assumes spsa_regs.svh supplies the numeric constants
`default_nettype none

package spsa_pkg;

    typedef enum logic [3:0]
    {
        CMD_CHECK      = 4'h0,
        CMD_RD_CFG     = 4'h1,
        CMD_WR_CFG     = 4'h2,
        CMD_RD_STAT    = 4'h3,
        CMD_WR_STAT    = 4'h4,
        CMD_RD_CTRL    = 4'h5,
        CMD_WR_CTRL    = 4'h6,
        CMD_CHECK_RESP = 4'h7
    } spsa_cmd_t;

    typedef struct packed
    {
        logic [2:0]  sclk_sync;
        logic [2:0]  sel_sync;
        logic [1:0]  mosi_sync;
        logic [15:0] in_sh;
        logic [15:0] out_sh;
        logic [4:0]  pulses;
        logic [15:0] resp;
        logic [7:0]  sensor;
        logic [7:0]  sysflt;
        logic [7:0]  ctrl;
        logic        miso;
        logic        miso_oe_n;
        logic        frame_ok;
    } spsa_dev_t;

    typedef enum logic [4:0]
    {
        H_IDLE  = 5'b00001,
        H_SETUP = 5'b00010,
        H_HIGH  = 5'b00100,
        H_LOW   = 5'b01000,
        H_HOLD  = 5'b10000
    } spsa_hstate_t;

    typedef struct packed
    {
        spsa_hstate_t st;
        logic [3:0]   div;
        logic [4:0]   bit_cnt;
        logic         sclk;
        logic         sel_n;
        logic         mosi;
        logic [15:0]  tx_sh;
        logic [15:0]  tx_word;
        logic [15:0]  rx_sh;
        logic [15:0]  rx_word;
        logic [15:0]  rdata;
        logic [1:0]   miso_sync;
    } spsa_host_t;

endpackage : spsa_pkg

`default_nettype wire

// [core/spsa_link_if.sv]
// serial link wires between host controller and status device
// assumes the bench resolves the tri-state output from miso_oe_n
`default_nettype none

interface spsa_link_if;
    logic sclk;
    logic select_n;
    logic mosi;
    logic miso;
    logic miso_oe_n;

    modport device
    (
        input  sclk,
        input  select_n,
        input  mosi,
        output miso,
        output miso_oe_n
    );

    modport host
    (
        output sclk,
        output select_n,
        output mosi,
        input  miso,
        input  miso_oe_n
    );
endinterface : spsa_link_if

`default_nettype wire

// [core/spsa_host.sv]
// host end: serial master driven through a small register port
// assumes miso arrives asynchronously; one device per select line
`include "spsa_regs.svh"
`default_nettype none

module spsa_host
(
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    spsa_link_if.host        link,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [15:0]      rdata_out,
    output logic             busy_out
);

    spsa_pkg::spsa_host_t h_ff;
    spsa_pkg::spsa_host_t nxt_h;
    logic                 half_done;

    always_comb
    begin
        nxt_h = h_ff;
        nxt_h.miso_sync = {h_ff.miso_sync[0], link.miso};
        half_done = (h_ff.div == (`SPSA_HALF_CYCLES - 4'h1));
        nxt_h.div = half_done ? 4'h0 : (h_ff.div + 4'h1);
        nxt_h.rdata = 16'h0000;

        if (rd_in)
        begin
            case (addr_in)
                `SPSA_HOST_TX_ADDR: nxt_h.rdata = h_ff.tx_word;
                `SPSA_HOST_RX_ADDR: nxt_h.rdata = h_ff.rx_word;
                `SPSA_HOST_ST_ADDR:
                    nxt_h.rdata = {15'h0000, h_ff.st != spsa_pkg::H_IDLE};
                default:            nxt_h.rdata = 16'h0000;
            endcase
        end

        case (h_ff.st)
            spsa_pkg::H_IDLE:
            begin
                nxt_h.div = 4'h0;
                if (wr_in && addr_in == `SPSA_HOST_TX_ADDR)
                begin
                    // select falls with the clock low
                    nxt_h.tx_word = wdata_in;
                    nxt_h.tx_sh   = wdata_in;
                    nxt_h.mosi    = wdata_in[15];
                    nxt_h.sel_n   = 1'b0;
                    nxt_h.bit_cnt = 5'h00;
                    nxt_h.st      = spsa_pkg::H_SETUP;
                end
            end
            spsa_pkg::H_SETUP,
            spsa_pkg::H_LOW:
            begin
                if (half_done)
                begin
                    nxt_h.sclk = 1'b1;
                    nxt_h.st   = spsa_pkg::H_HIGH;
                end
            end
            spsa_pkg::H_HIGH:
            begin
                if (half_done)
                begin
                    nxt_h.rx_sh   = {h_ff.rx_sh[14:0], h_ff.miso_sync[1]};
                    nxt_h.sclk    = 1'b0;
                    nxt_h.bit_cnt = h_ff.bit_cnt + 5'h01;
                    if (h_ff.bit_cnt == (`SPSA_FRAME_BITS - 5'h01))
                    begin
                        nxt_h.st = spsa_pkg::H_HOLD;
                    end
                    else
                    begin
                        nxt_h.tx_sh = {h_ff.tx_sh[14:0], 1'b0};
                        nxt_h.mosi  = h_ff.tx_sh[14];
                        nxt_h.st    = spsa_pkg::H_LOW;
                    end
                end
            end
            spsa_pkg::H_HOLD:
            begin
                if (half_done && !h_ff.sel_n)
                begin
                    nxt_h.sel_n   = 1'b1;
                    nxt_h.rx_word = h_ff.rx_sh;
                end
                else if (half_done)
                begin
                    nxt_h.st = spsa_pkg::H_IDLE;
                end
            end
            default:
            begin
                nxt_h.st    = spsa_pkg::H_IDLE;
                nxt_h.sclk  = 1'b0;
                nxt_h.sel_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            h_ff       <= '0;
            h_ff.st    <= spsa_pkg::H_IDLE;
            h_ff.sel_n <= 1'b1;
        end
        else
        begin
            h_ff <= nxt_h;
        end
    end

    assign link.sclk     = h_ff.sclk;
    assign link.select_n = h_ff.sel_n;
    assign link.mosi     = h_ff.mosi;
    assign rdata_out     = h_ff.rdata;
    assign busy_out      = (h_ff.st != spsa_pkg::H_IDLE);

endmodule : spsa_host

`default_nettype wire

// [testbench/spsa_link_assertions.sv]
// checker: timing relations on the serial link wires
// assumes host and device ends joined by one link interface
`default_nettype none

module spsa_link_assertions
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       sclk_q_ff;
    logic [4:0] rises_ff;

    // counts clock rises inside a frame
    always_ff @(posedge core_clk_in)
    begin
        sclk_q_ff <= sclk;
        if (!rstn_in || select_n)
            rises_ff <= 5'h00;
        else if (sclk && !sclk_q_ff)
            rises_ff <= rises_ff + 5'h01;
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    a_idle_released: assert property (select_n[*8] |-> miso_oe_n && !miso)
        else $error("output driven while deselected");
    a_frame_driven: assert property (!select_n[*8] |-> !miso_oe_n)
        else $error("output not driven in frame");
    a_release_prompt: assert property ($rose(select_n) |-> ##[1:6] miso_oe_n)
        else $error("output not released after frame");
    a_select_clk_low: assert property ($changed(select_n) |-> !sclk)
        else $error("select moved with clock high");
    a_clk_idle: assert property (select_n |-> !sclk)
        else $error("clock pulse outside frame");
    a_miso_steady: assert property ($rose(sclk) |-> $stable(miso)[*8])
        else $error("output moved while clock high");
    a_mosi_steady: assert property (sclk |-> $stable(mosi))
        else $error("input data moved while clock high");
    a_sixteen_pulses: assert property ($rose(select_n) |-> rises_ff == 5'h10)
        else $error("frame without sixteen pulses");
endmodule : spsa_link_assertions

`default_nettype wire

// [testbench/spi_slave_status_access_tb.sv]
// bench: host register port drives frames into the device end
// assumes shared core_clk_in; a second link carries bad frames
`include "spsa_regs.svh"
`default_nettype none

module spi_slave_status_access_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk_in;
    logic        rstn_in;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        busy;
    logic [3:0]  peak;
    logic        pos;
    logic        neg;
    logic        hot;
    logic        st_en;
    logic        err;
    logic        hot_flag;
    logic        err2;
    logic [15:0] d;
    logic        fok;
    logic        fok2;
    int          ok_cnt;
    int          ok2_cnt;
    int          errors;
    int          comparisons;

    spsa_link_if link ();
    spsa_link_if link2 ();

    spsa_host u_spsa_host
    (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .link        (link),
        .addr_in     (addr),
        .wdata_in    (wdata),
        .wr_in       (wr),
        .rd_in       (rd),
        .rdata_out   (rdata),
        .busy_out    (busy)
    );

    spsa_device #(.MODEL_ID(3'h2), .REV_ID(5'h11)) u_spsa_device
    (
        .core_clk_in             (core_clk_in),
        .rstn_in                 (rstn_in),
        .link                    (link),
        .peak_code_in            (peak),
        .pos_clamp_in            (pos),
        .neg_clamp_in            (neg),
        .overheat_in             (hot),
        .self_test_enable_out    (st_en),
        .spi_error_out           (err),
        .kline_overheat_flag_out (hot_flag),
        .frame_ok_out            (fok)
    );

    spsa_device u_spsa_device_bad
    (
        .core_clk_in             (core_clk_in),
        .rstn_in                 (rstn_in),
        .link                    (link2),
        .peak_code_in            (peak),
        .pos_clamp_in            (pos),
        .neg_clamp_in            (neg),
        .overheat_in             (hot),
        .self_test_enable_out    (),
        .spi_error_out           (err2),
        .kline_overheat_flag_out (),
        .frame_ok_out            (fok2)
    );

    spsa_link_assertions u_spsa_link_assertions
    (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .sclk        (link.sclk),
        .select_n    (link.select_n),
        .mosi        (link.mosi),
        .miso        (link.miso),
        .miso_oe_n   (link.miso_oe_n)
    );

    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // counts acted-on frames of both device ends
    always @(posedge core_clk_in)
    begin
        if (!rstn_in)
        begin
            ok_cnt  <= 0;
            ok2_cnt <= 0;
        end
        else
        begin
            if (fok)
                ok_cnt <= ok_cnt + 1;
            if (fok2)
                ok2_cnt <= ok2_cnt + 1;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic flag(input logic v, input logic e, input string what);
        chk({15'h0000, v}, {15'h0000, e}, what);
    endtask : flag

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk_in);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge core_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    // one frame; checks the word shifted back by the device against exp
    task automatic xfer(input logic [15:0] w, input logic [15:0] exp);
        logic [15:0] v;
        int          n;
        wr_reg(`SPSA_HOST_TX_ADDR, w);
        #1 flag(busy, 1'b1, "busy pin set");
        n = 0;
        v = 16'h0001;
        while (v[0] !== 1'b0 && n < 200)
        begin
            rd_reg(`SPSA_HOST_ST_ADDR, v);
            n++;
        end
        chk(v & 16'h0001, 16'h0000, "busy");
        flag(busy, 1'b0, "busy pin clear");
        rd_reg(`SPSA_HOST_RX_ADDR, v);
        chk(v, exp, "response");
    endtask : xfer

    // frame of n pulses on the second link, 80 ns clock
    task automatic frame2(input int n, input logic [15:0] w);
        logic [15:0] sh;
        sh = w;
        @(posedge core_clk_in);
        link2.select_n <= 1'b0;
        link2.mosi     <= sh[15];
        repeat (n)
        begin
            repeat (4) @(posedge core_clk_in);
            link2.sclk <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            link2.sclk <= 1'b0;
            sh = sh << 1;
            link2.mosi <= sh[15];
        end
        repeat (4) @(posedge core_clk_in);
        link2.select_n <= 1'b1;
        repeat (12) @(posedge core_clk_in);
    endtask : frame2

    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial
    begin
        #200000;
        errors++;
        conclude();
    end

    initial
    begin
        errors = 0;
        comparisons = 0;
        rstn_in = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        peak = 4'h0;
        pos = 1'b0;
        neg = 1'b0;
        hot = 1'b0;
        link2.sclk = 1'b0;
        link2.select_n = 1'b1;
        link2.mosi = 1'b0;
        repeat (6) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        xfer(16'h0abc, 16'h0000);
        xfer(16'h3f00, 16'h7abc);
        @(posedge core_clk_in);
        peak <= 4'h9;
        pos  <= 1'b1;
        hot  <= 1'b1;
        @(posedge core_clk_in);
        hot <= 1'b0;
        xfer(16'h3b00, 16'h3f51);
        flag(hot_flag, 1'b1, "overheat set");
        xfer(16'h4b00, 16'h3b95);
        flag(hot_flag, 1'b0, "overheat clear");
        xfer(16'h6e01, 16'h4b00);
        flag(st_en, 1'b1, "self test on");
        xfer(16'h4bff, 16'h6e01);
        @(posedge core_clk_in);
        peak <= 4'h0;
        pos  <= 1'b0;
        neg  <= 1'b1;
        xfer(16'h3b00, 16'h4bff);
        xfer(16'h6e00, 16'h3bf7);
        flag(st_en, 1'b0, "self test off");
        xfer(16'h3b00, 16'h6e00);
        xfer(16'h8000, 16'h3b03);
        flag(err, 1'b1, "bad command");
        xfer(16'h4d00, 16'h3b03);
        flag(err, 1'b0, "error cleared");
        xfer(16'h3500, 16'h4d00);
        flag(err, 1'b1, "bad address");
        xfer(16'h3d00, 16'h4d00);
        xfer(16'h0000, 16'h3d08);
        rd_reg(4'h2, d);
        chk(d, 16'h0000, "unmapped");
        chk(ok_cnt[15:0], 16'h000c, "frames acted");
        frame2(15, 16'h0000);
        flag(err2, 1'b1, "short frame");
        chk(ok2_cnt[15:0], 16'h0000, "short not acted");
        frame2(16, 16'h4d00);
        flag(err2, 1'b0, "whole frame");
        chk(ok2_cnt[15:0], 16'h0001, "whole acted");
        frame2(17, 16'h0000);
        flag(err2, 1'b1, "long frame");
        chk(ok2_cnt[15:0], 16'h0001, "long not acted");
        conclude();
    end
endmodule : spi_slave_status_access_tb

`default_nettype wire
